// file: shared/rxsc_map.svh
// Register offsets, field positions, reset values and limits of the rx counters
`ifndef RXSC_MAP_SVH
`define RXSC_MAP_SVH

// Register bus geometry
`define RXSC_ADDR_W 8
`define RXSC_DATA_W 32

// Counter bank: five one-word registers from the base, one word apart
`define RXSC_OFS_CNT_BASE 8'h00
`define RXSC_OFS_CNT_STEP 8'h04
`define RXSC_OFS_RXERR 8'h00
`define RXSC_OFS_SHORT 8'h04
`define RXSC_OFS_LONG 8'h08
`define RXSC_OFS_RESID 8'h0C
`define RXSC_OFS_MCAST 8'h10

// Control and status words
`define RXSC_OFS_LIMIT 8'h14
`define RXSC_OFS_CTRL 8'h18
`define RXSC_OFS_STAT 8'h1C
`define RXSC_OFS_LAST 8'h20

// Counter geometry
`define RXSC_CNT_W 16
`define RXSC_CNT_NUM 5
`define RXSC_CNT_MAX 16'hFFFF
`define RXSC_CNT_RST 16'h0000

// Frame length checks, in bytes
`define RXSC_LEN_W 16
`define RXSC_MIN_FRAME 16'h0040
`define RXSC_LIMIT_RST 16'h05EE

// Control word fields
`define RXSC_CTRL_EN_BIT 0
`define RXSC_CTRL_RST 1'h1

// Status word fields
`define RXSC_STAT_SAT_LSB 0
`define RXSC_STAT_FRAME_BIT 8

`endif

// file: shared/rxsc_pkg.sv
// Types shared by the receive statistics counter block
package rxsc_pkg;

	// Index of each counter in the bank
	typedef enum logic [2:0] {
		CNT_RXERR,
		CNT_SHORT,
		CNT_LONG,
		CNT_RESID,
		CNT_MCAST
	} rxsc_cnt_e;

	// Receive line tracking
	typedef enum logic {
		RX_IDLE,
		RX_FRAME
	} rxsc_rx_e;

	typedef logic [15:0] rxsc_count_t;

	// End-of-frame report from the frame parser, same clock
	typedef struct packed {
		logic done;
		logic [15:0] len_bytes;
		logic residual;
		logic multicast;
	} rxsc_frame_s;

endpackage

// file: rtl/rxsc_pin_sync.sv
// Two-flop synchroniser for pins arriving from the PHY
module rxsc_pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
	output logic [WIDTH-1:0] pin_out // Synchronised levels
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign pin_out = sync_r;

endmodule

// file: rtl/rxsc_sat_counter.sv
// Saturating event counter with a clear that overrides counting
`include "rxsc_map.svh"

module rxsc_sat_counter #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic inc, // One-cycle count event
	input wire logic clr, // One-cycle clear
	output logic [WIDTH-1:0] count, // Current count
	output logic saturated // Count stands at its top value
);

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	wire at_top = (count_r == {WIDTH{1'b1}});

	// Clear first, then a count that stops at the top
	assign count_nxt = clr ? '0 :
		(inc && !at_top) ? count_r + 1'b1 : count_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count = count_r;
	assign saturated = at_top;

endmodule

// file: rtl/rxsc_rx_stat.sv
// Receive error statistics counters with their register port
//
// Operation
// - Each counter is 16 bits wide in the low half of a 32-bit word.
// - The receive error counter steps once per rising receive-error pin while a frame is in progress.
// - Every counter stops at 65,535 and holds there on further events.
// - Any write to a counter register clears it, whatever the data.
// - Bits 31 to 16 of every counter register read as zero.
// - The short counter steps for each frame below 64 bytes.
// - The long counter steps for each whole-byte frame longer than the limit.
// - A frame with residual bits never steps the long counter.
// - The residual counter steps for each frame not a whole byte long.
// - The multicast counter steps for each multicast frame.
//
// Implementation choices: strobed register access and the register offsets.
`include "rxsc_map.svh"

module rxsc_rx_stat #(
	parameter int CNT_W = `RXSC_CNT_W,
	parameter logic [15:0] LIMIT_RESET = `RXSC_LIMIT_RST
) (
	input wire logic sys_clk, // System clock, 250 MHz
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe, one cycle
	input wire logic reg_rd, // Read strobe, one cycle
	output logic [31:0] reg_rdata, // Read data, cycle after the strobe
	input wire logic phy_rx_dv, // PHY receive data valid pin
	input wire logic phy_rx_er, // PHY receive error pin
	input wire rxsc_pkg::rxsc_frame_s frame_rpt, // End-of-frame report
	output logic [4:0] count_sat // Counters at their top value
);

	localparam int NUM = `RXSC_CNT_NUM;

	// Pin synchronisation
	logic [1:0] pin_raw;
	logic [1:0] pin_sync;
	logic rx_dv_s;
	logic rx_er_s;

	assign pin_raw = {phy_rx_er, phy_rx_dv};

	rxsc_pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pin_in(pin_raw),
		.pin_out(pin_sync)
	);

	assign rx_dv_s = pin_sync[0];
	assign rx_er_s = pin_sync[1];

	// Receive line tracking
	rxsc_pkg::rxsc_rx_e rx_state_r;
	rxsc_pkg::rxsc_rx_e rx_state_nxt;
	logic rx_er_d_r;
	logic er_rise;
	logic in_frame;

	always_comb begin
		rx_state_nxt = rx_state_r;
		case (rx_state_r)
			rxsc_pkg::RX_IDLE: begin
				if (rx_dv_s) begin
					rx_state_nxt = rxsc_pkg::RX_FRAME;
				end
			end
			rxsc_pkg::RX_FRAME: begin
				if (!rx_dv_s) begin
					rx_state_nxt = rxsc_pkg::RX_IDLE;
				end
			end
			default: begin
				rx_state_nxt = rxsc_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state_r <= rxsc_pkg::RX_IDLE;
			rx_er_d_r <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_er_d_r <= rx_er_s;
		end
	end

	// Only the assertion edge of the error pin counts, once per episode
	assign er_rise = rx_er_s && !rx_er_d_r;
	assign in_frame = rx_dv_s || (rx_state_r == rxsc_pkg::RX_FRAME);

	// Software registers
	logic [15:0] limit_r;
	logic [15:0] limit_nxt;
	logic ctrl_en_r;
	logic ctrl_en_nxt;
	logic [3:0] last_r;
	logic [3:0] last_nxt;

	// Address decode
	wire hit_limit = (reg_addr == `RXSC_OFS_LIMIT);
	wire hit_ctrl = (reg_addr == `RXSC_OFS_CTRL);
	wire hit_stat = (reg_addr == `RXSC_OFS_STAT);
	wire hit_last = (reg_addr == `RXSC_OFS_LAST);
	logic [NUM-1:0] hit_cnt;

	assign limit_nxt = (reg_wr && hit_limit) ? reg_wdata[15:0] : limit_r;
	assign ctrl_en_nxt = (reg_wr && hit_ctrl) ?
		reg_wdata[`RXSC_CTRL_EN_BIT] : ctrl_en_r;

	// Frame classification on the parser's end-of-frame report
	logic frm_done;
	logic is_short;
	logic is_long;
	logic is_resid;
	logic is_mcast;

	assign frm_done = frame_rpt.done;
	assign is_short = frame_rpt.len_bytes < `RXSC_MIN_FRAME;
	// Strictly above the limit: a frame exactly at the limit is not long
	assign is_long = (frame_rpt.len_bytes > limit_r)
		&& !frame_rpt.residual;
	assign is_resid = frame_rpt.residual;
	assign is_mcast = frame_rpt.multicast;

	// Last frame flags, kept for software to inspect
	assign last_nxt = frm_done ?
		{is_mcast, is_resid, is_long, is_short} : last_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			limit_r <= LIMIT_RESET;
			ctrl_en_r <= `RXSC_CTRL_RST;
			last_r <= 4'h0;
		end else begin
			limit_r <= limit_nxt;
			ctrl_en_r <= ctrl_en_nxt;
			last_r <= last_nxt;
		end
	end

	// Count events, gated by the enable bit
	logic [NUM-1:0] cnt_ev;

	assign cnt_ev[rxsc_pkg::CNT_RXERR] = ctrl_en_r && er_rise
		&& in_frame;
	assign cnt_ev[rxsc_pkg::CNT_SHORT] = ctrl_en_r && frm_done
		&& is_short;
	assign cnt_ev[rxsc_pkg::CNT_LONG] = ctrl_en_r && frm_done
		&& is_long;
	assign cnt_ev[rxsc_pkg::CNT_RESID] = ctrl_en_r && frm_done
		&& is_resid;
	assign cnt_ev[rxsc_pkg::CNT_MCAST] = ctrl_en_r && frm_done
		&& is_mcast;

	// Counter bank
	logic [CNT_W-1:0] cnt_val [NUM];
	logic [NUM-1:0] cnt_clr;
	logic [NUM-1:0] cnt_top;

	genvar gi;
	generate
		for (gi = 0; gi < NUM; gi++) begin : g_cnt
			assign hit_cnt[gi] = (reg_addr == 8'(`RXSC_OFS_CNT_BASE
				+ gi * `RXSC_OFS_CNT_STEP));
			// Data value is ignored on a counter write
			assign cnt_clr[gi] = reg_wr && hit_cnt[gi];
			rxsc_sat_counter #(
				.WIDTH(CNT_W)
			) u_cnt (
				.sys_clk(sys_clk),
				.arst_n(arst_n),
				.inc(cnt_ev[gi]),
				.clr(cnt_clr[gi]),
				.count(cnt_val[gi]),
				.saturated(cnt_top[gi])
			);
		end
	endgenerate

	// Read selection
	logic [31:0] rd_cnt;
	logic [31:0] rd_limit;
	logic [31:0] rd_ctrl;
	logic [31:0] rd_stat;
	logic [31:0] rd_last;
	logic [31:0] rd_mux;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [4:0] sat_r;

	// Upper half of a counter word is reserved and reads as zero
	assign rd_cnt = hit_cnt[0] ? {16'h0000, cnt_val[0]} :
		hit_cnt[1] ? {16'h0000, cnt_val[1]} :
		hit_cnt[2] ? {16'h0000, cnt_val[2]} :
		hit_cnt[3] ? {16'h0000, cnt_val[3]} :
		hit_cnt[4] ? {16'h0000, cnt_val[4]} : 32'h00000000;
	assign rd_limit = {16'h0000, limit_r};
	assign rd_ctrl = {31'h00000000, ctrl_en_r};
	assign rd_stat = {23'h000000, in_frame, 3'h0, cnt_top};
	assign rd_last = {28'h0000000, last_r};

	// Unmapped addresses read as zero
	assign rd_mux = (|hit_cnt) ? rd_cnt :
		hit_limit ? rd_limit :
		hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat :
		hit_last ? rd_last : 32'h00000000;

	// Data stands only in the cycle after the read strobe
	assign rdata_nxt = reg_rd ? rd_mux : 32'h00000000;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 32'h00000000;
			sat_r <= 5'h00;
		end else begin
			rdata_r <= rdata_nxt;
			sat_r <= cnt_top;
		end
	end

	assign reg_rdata = rdata_r;
	assign count_sat = sat_r;

endmodule

// file: sim/rxsc_rx_stat_props.sv
// Checker for the rx statistics counter block
module rxsc_rx_stat_props #(
	parameter logic [15:0] LIMIT_RESET = 16'h05EE
) (
	input wire logic sys_clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire rxsc_pkg::rxsc_frame_s frame_rpt, // Frame report
	input wire logic [4:0] count_sat // Saturated flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	function automatic logic [15:0] nx(logic [15:0] v, logic c);
		return (v == 16'hFFFF) ? v : v + 16'(c);
	endfunction
	// Two reads in a row see exactly the events of the first cycle
	property step_p(logic [7:0] a, logic c);
		reg_rd && reg_addr == a ##1 reg_rd && reg_addr == a
		|=> reg_rdata[15:0] == nx($past(reg_rdata[15:0]), $past(c, 2));
	endproperty
	short_step_a: assert property (step_p(8'h04,
		frame_rpt.done && frame_rpt.len_bytes < 16'h0040))
		else $error("short count step");
	long_step_a: assert property (step_p(8'h08,
		frame_rpt.done && frame_rpt.len_bytes > LIMIT_RESET &&
		!frame_rpt.residual)) else $error("long count step");
	resid_step_a: assert property (step_p(8'h0C,
		frame_rpt.done && frame_rpt.residual)) else $error("residual step");
	mcast_step_a: assert property (step_p(8'h10,
		frame_rpt.done && frame_rpt.multicast)) else $error("multicast step");
	upper_zero_a: assert property ($past(reg_rd) &&
		$past(reg_addr) < 8'h14 |-> reg_rdata[31:16] == 16'h0000)
		else $error("upper bits set");
	clear_wins_a: assert property (reg_wr && reg_addr < 8'h14
		##1 reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == 32'h0)
		else $error("clear not seen");
	sat_hold_a: assert property (!reg_wr && !$past(reg_wr)
		|=> (count_sat & $past(count_sat)) == $past(count_sat))
		else $error("saturation lost");
	sat_flag_a: assert property ($past(reg_rd) &&
		$past(reg_addr) == 8'h10 && reg_rdata[15:0] == 16'hFFFF
		|-> count_sat[4]) else $error("saturation flag missing");
	cover property (count_sat[4]);
	cover property (reg_wr ##1 reg_rd);
	cover property (frame_rpt.done && frame_rpt.residual);
endmodule

bind rxsc_rx_stat rxsc_rx_stat_props #(.LIMIT_RESET(LIMIT_RESET))
	u_rxsc_rx_stat_props (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .frame_rpt, .count_sat);

// file: sim/rxsc_phy_model.sv
// Receive-side PHY model driving the valid and error pins
module rxsc_phy_model (
	input wire logic sys_clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic go, // Start a frame
	input wire logic [1:0] mode, // 0 clean, 1 errors, 2 stray errors
	output logic rx_dv, // Data valid
	output logic rx_er // Receive error
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] t_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			t_r <= 5'h00;
			rx_dv <= 1'b0;
			rx_er <= 1'b0;
		end else begin
			if (go || t_r != 5'h00)
				t_r <= (t_r == 5'h18) ? 5'h00 : t_r + 5'h01;
			rx_dv <= mode != 2'h2 && t_r != 5'h00 && t_r <= 5'h10;
			// Two error bursts, the first held for four cycles
			rx_er <= mode != 2'h0 &&
				(t_r inside {[5'h04:5'h07], [5'h0A:5'h0B]});
		end
	end
endmodule

// file: sim/rxsc_rx_stat_tb.sv
// Testbench for the rx statistics counter block
module rxsc_rx_stat_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [15:0] len;
		logic res;
		logic mc;
		logic [3:0] inc;
	} rxsc_row_s;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic phy_rx_dv;
	logic phy_rx_er;
	rxsc_pkg::rxsc_frame_s frame_rpt = '0;
	logic [4:0] count_sat;
	logic go = 1'b0;
	logic [1:0] mode = 2'h0;
	int err_total = 0;
	int cmp_count = 0;
	logic [15:0] cnt [4] = '{default: 16'h0000};
	// Increment bits: short, long, residual, multicast
	rxsc_row_s rows [7] = '{'{16'h003F, 1'b0, 1'b0, 4'h1},
		'{16'h0040, 1'b0, 1'b0, 4'h0}, '{16'h05EE, 1'b0, 1'b0, 4'h0},
		'{16'h05EF, 1'b0, 1'b0, 4'h2}, '{16'h05EF, 1'b1, 1'b0, 4'h4},
		'{16'h0064, 1'b0, 1'b1, 4'h8}, '{16'h000A, 1'b1, 1'b1, 4'hD}};
	rxsc_rx_stat u_rxsc_rx_stat (.sys_clk, .arst_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .phy_rx_dv, .phy_rx_er, .frame_rpt,
		.count_sat);
	rxsc_phy_model u_rxsc_phy_model (.sys_clk, .arst_n, .go, .mode,
		.rx_dv(phy_rx_dv), .rx_er(phy_rx_er));
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	// Frame report beside the first of two reads of counter k
	task automatic probe(int k, rxsc_row_s r);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= 8'(4 * k + 4);
		frame_rpt <= '{1'b1, r.len, r.res, r.mc};
		@(posedge sys_clk);
		frame_rpt.done <= 1'b0;
		#1;
		chk(reg_rdata, {16'h0, cnt[k]});
		for (int j = 0; j < 4; j++)
			cnt[j] += 16'(r.inc[j]);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, {16'h0, cnt[k]});
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// One end-of-frame report, done high for a single cycle
	task automatic fr(logic [15:0] len, logic res, logic mc);
		@(posedge sys_clk);
		frame_rpt <= '{1'b1, len, res, mc};
		@(posedge sys_clk);
		frame_rpt.done <= 1'b0;
	endtask
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		for (int a = 0; a <= 16; a += 4)
			rd(8'(a), 32'h0);
		rd(8'h40, 32'h0);
		rd(8'h14, 32'h000005EE);
		rd(8'h18, 32'h00000001);
		foreach (rows[i])
			for (int k = 0; k < 4; k++)
				probe(k, rows[i]);
		for (int m = 0; m < 3; m++) begin
			@(posedge sys_clk);
			go <= 1'b1;
			mode <= 2'(m);
			@(posedge sys_clk);
			go <= 1'b0;
			repeat (30) @(posedge sys_clk);
		end
		rd(8'h00, 32'h2);
		// Programmed limit: one above counts, one at the limit does not
		wr(8'h14, 32'h00000064);
		rd(8'h14, 32'h00000064);
		fr(16'h0065, 1'b0, 1'b0);
		fr(16'h0064, 1'b0, 1'b0);
		rd(8'h08, 32'h00000005);
		wr(8'h14, 32'h000005EE);
		// Counting disabled: flags still latch, counters stand still
		wr(8'h18, 32'h00000000);
		fr(16'h003F, 1'b1, 1'b1);
		rd(8'h04, 32'h00000008);
		rd(8'h0C, 32'h00000008);
		rd(8'h20, 32'h0000000D);
		wr(8'h18, 32'h00000001);
		rd(8'h18, 32'h00000001);
		rd(8'h1C, 32'h00000000);
		@(posedge sys_clk);
		frame_rpt <= '{1'b1, 16'h0064, 1'b0, 1'b1};
		repeat (65540) @(posedge sys_clk);
		frame_rpt.done <= 1'b0;
		rd(8'h10, 32'h0000FFFF);
		chk({27'h0, count_sat}, 32'h10);
		rd(8'h1C, 32'h00000010);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= 8'h10;
		reg_wdata <= 32'h0000ABCD;
		frame_rpt.done <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		frame_rpt.done <= 1'b0;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk({27'h0, count_sat}, 32'h0);
		// Mid-run reset brings counters and control back to defaults
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(8'h0C, 32'h00000000);
		rd(8'h14, 32'h000005EE);
		rd(8'h18, 32'h00000001);
		tally_and_finish();
	end
endmodule
